// [testbench.sv]
// Self-checking bench for the trigger front end and pulse generator
`timescale 1ns/10ps
`include "trig_defs.svh"

module testbench;
	// Short microsecond keeps long intervals cheap
	localparam int US = 2;
	localparam int DBT[8] = '{0, `DB_T1_US, `DB_T2_US, `DB_T3_US,
		`DB_T4_US, `DB_T5_US, `DB_T6_US, `DB_T7_US};
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	logic        go = 1'b0;
	logic [1:0]  line = 2'h0;
	logic        lvl = 1'b0;
	logic        ring = 1'b0;
	logic [31:0] rdata, v;
	logic        external_input_a, external_input_b, cable_ctrl_1;
	logic        cable_ctrl_2, exposure_start, exposure_active;
	logic        pulse_out, pg_running, prev;
	int          failures = 0;
	int          total_checks = 0;
	int          starts = 0;
	int          rises = 0;
	int          cycles = 0;
	int          n, hi, lo, s0;

	always #4 clk = ~clk;

	trigger_and_pulse_generator #(.US_CYCLES(16'(US))) uut (.clk, .arst_n,
		.addr, .wdata, .wr_stb, .rd_stb, .rdata, .external_input_a,
		.external_input_b, .cable_ctrl_1, .cable_ctrl_2, .exposure_start,
		.exposure_active, .pulse_out, .pg_running);
	trig_source_model src (.clk, .go, .line, .lvl, .ring, .external_input_a,
		.external_input_b, .cable_ctrl_1, .cable_ctrl_2);

	// Event counters and run limit
	always @(posedge clk)
	begin
		cycles++;
		prev <= pulse_out;
		if (exposure_start === 1'b1)
			starts++;
		if (pulse_out === 1'b1 && prev !== 1'b1)
			rises++;
		if (cycles == 100000)
		begin
			failures++;
			results();
		end
	end

	// ----
	// Access and measurement tasks
	// ----
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		wr_stb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rc(string name, logic [7:0] a, logic [31:0] e);
		@(posedge clk);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		v = rdata;
		if (name != "")
			check(name, v, e);
	endtask
	// Move one far-side line, then count cycles to a start (lim if none)
	task automatic pin(logic [1:0] l, logic x, logic r, int lim,
		output int c);
		@(posedge clk);
		go <= 1'b1;
		line <= l;
		lvl <= x;
		ring <= r;
		@(posedge clk);
		go <= 1'b0;
		#1;
		c = 0;
		while (exposure_start !== 1'b1 && c < lim)
		begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask
	// Cycles for which the generator output keeps level x
	task automatic hold(logic x, output int c);
		#1;
		c = 0;
		while (pulse_out === x && c < 9000)
		begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask
	function automatic logic [31:0] cw(logic [2:0] s, logic f,
		logic [2:0] d, logic [1:0] x);
		return {22'h0, x, d, f, s, 1'b1};
	endfunction
	task automatic results();
		if (failures == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----
	// Main sequence
	// ----
	initial
	begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rc("ctrl reset", 8'h00, 32'h60);
		rc("period reset", 8'h10, 32'h1);
		rc("unmapped", 8'h40, 32'h0);
		wr(8'h00, 32'h6C);
		rc("bad source", 8'h00, 32'h60);
		wr(8'h04, 32'hFFFFF);
		rc("delay clamp", 8'h04, 32'hF4240);
		wr(8'h18, 32'h0);
		rc("count low", 8'h18, 32'h1);
		wr(8'h18, 32'h11170);
		rc("count high", 8'h18, 32'hFFDC);
		wr(8'h04, 32'h0);
		// Each wired source with alternating edge; a foreign line is ignored
		for (int s = 0; s < 4; s++)
		begin
			wr(8'h00, cw(3'(s), s[0], 3'h0, 2'h0));
			pin(2'(s + 1), 1'b1, 1'b0, 12, n);
			check("other line", n, 12);
			pin(2'(s + 1), 1'b0, 1'b0, 12, n);
			pin(2'(s), 1'b1, 1'b0, 12, n);
			check("rising", n inside {[3:6]}, !s[0]);
			pin(2'(s), 1'b0, 1'b0, 12, n);
			check("falling", n inside {[3:6]}, s[0]);
		end
		wr(8'h00, cw(3'h0, 1'b0, 3'h0, 2'h0) & ~32'h1);
		pin(2'h0, 1'b1, 1'b0, 12, n);
		check("disabled", n, 12);
		pin(2'h0, 1'b0, 1'b0, 12, n);
		// Software fire counts once, and only with software source
		s0 = starts;
		wr(8'h00, cw(3'h5, 1'b0, 3'h0, 2'h0));
		wr(8'h08, 32'h1);
		wr(8'h00, cw(3'h0, 1'b0, 3'h0, 2'h0));
		wr(8'h08, 32'h1);
		repeat (4) @(posedge clk);
		check("soft", starts - s0, 1);
		wr(8'h04, 32'hA);
		pin(2'h0, 1'b1, 1'b0, 40, n);
		check("delay", n inside {[20:28]}, 1);
		pin(2'h0, 1'b0, 1'b0, 40, n);
		wr(8'h04, 32'h0);
		// Ringing edge then a too-short pulse under the 10 us filter
		wr(8'h00, cw(3'h0, 1'b0, 3'h1, 2'h0));
		s0 = starts;
		pin(2'h0, 1'b1, 1'b1, 60, n);
		check("ring latency", n inside {[30:46]}, 1);
		pin(2'h0, 1'b0, 1'b0, 40, n);
		pin(2'h0, 1'b1, 1'b0, 8, n);
		pin(2'h0, 1'b0, 1'b0, 40, n);
		check("ring once", starts - s0, 1);
		for (int k = 1; k < 8; k++)
		begin
			lo = US * DBT[k];
			wr(8'h00, cw(3'h0, !k[0], 3'(k), 2'h0));
			pin(2'h0, k[0], 1'b0, 2 * lo, n);
			check("debounce", n inside {[lo - 1:lo + 8]}, 1);
		end
		// Exposure follows the trigger level in pulse-width mode
		wr(8'h00, cw(3'h0, 1'b0, 3'h0, 2'h1));
		pin(2'h0, 1'b0, 1'b0, 12, n);
		pin(2'h0, 1'b1, 1'b0, 12, n);
		check("expo on", exposure_active, 1'b1);
		rc("expo status", 8'h20, 32'hA);
		pin(2'h0, 1'b0, 1'b0, 12, n);
		check("expo off", exposure_active, 1'b0);
		// Continuous train at every granularity, period 3 and width 1
		wr(8'h00, cw(3'h4, 1'b0, 3'h0, 2'h0));
		wr(8'h10, 32'h3);
		for (int g = 0; g < 4; g++)
		begin
			wr(8'h0C, 32'(g));
			s0 = starts;
			wr(8'h1C, 32'h1);
			hold(1'b0, n);
			hold(1'b1, n);
			hold(1'b0, lo);
			hold(1'b1, hi);
			n = US * 10 ** g;
			check("width", hi, n);
			check("gap", lo, 2 * n);
			check("period", hi + lo, 3 * n);
			rc("", 8'h20, 32'h0);
			check("running", v[0], 1'b1);
			check("internal", starts - s0 >= 2, 1);
			wr(8'h1C, 32'h2);
			#1;
			check("stopped", pg_running, 1'b0);
		end
		// Counted trains of one and three, then an aborted long train
		wr(8'h0C, 32'h4);
		for (int p = 1; p < 4; p += 2)
		begin
			wr(8'h18, 32'(p));
			s0 = rises;
			wr(8'h1C, 32'h1);
			repeat (24) @(posedge clk);
			#1;
			check("train", rises - s0, p);
			check("auto idle", pg_running, 1'b0);
		end
		wr(8'h18, 32'h64);
		wr(8'h1C, 32'h1);
		repeat (10) @(posedge clk);
		wr(8'h1C, 32'h2);
		#1;
		s0 = rises;
		check("abort", pg_running, 1'b0);
		repeat (20) @(posedge clk);
		check("no more", rises - s0, 0);
		results();
	end
endmodule

// [trig_asserts.sv]
// Port-level assertions for the trigger block
`timescale 1ns/10ps

module trig_asserts
(
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [31:0] rdata,
	input wire logic        exposure_active,
	input wire logic        pulse_out,
	input wire logic        pg_running
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// ----
	// Command and status accesses
	// ----
	sequence s_start;
		wr_stb && addr == 8'h1C && wdata[0] && !wdata[1];
	endsequence
	sequence s_stop;
		wr_stb && addr == 8'h1C && wdata[1];
	endsequence
	sequence s_stat;
		rd_stb && addr == 8'h20;
	endsequence

	// Read data stand only in the cycle after a read
	property p_idle_rd;
		!rd_stb |=> rdata == 32'h0;
	endproperty
	a_idle_rd: assert property (p_idle_rd)
		else $error("read data outside read cycle");

	// Status reports run state and exposure level of the read cycle
	property p_stat_run;
		s_stat |=> rdata[0] == $past(pg_running);
	endproperty
	a_stat_run: assert property (p_stat_run)
		else $error("status run bit wrong");
	property p_stat_expo;
		s_stat |=> rdata[1] == $past(exposure_active);
	endproperty
	a_stat_expo: assert property (p_stat_expo)
		else $error("status exposure bit wrong");

	// Start from hold runs next cycle; stop halts next cycle
	property p_start;
		s_start ##0 !pg_running |=> pg_running;
	endproperty
	a_start: assert property (p_start)
		else $error("start did not run generator");
	property p_stop;
		s_stop ##0 pg_running |=> !pg_running;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop did not halt generator");

	// Running only begins from a start command
	property p_rise;
		$rose(pg_running) |-> $past(wr_stb) && $past(addr) == 8'h1C &&
			$past(wdata[0]);
	endproperty
	a_rise: assert property (p_rise)
		else $error("generator ran without start");

	// Output is quiet on hold and only rises while running
	property p_hold;
		!pg_running && !$past(pg_running) |-> !pulse_out;
	endproperty
	a_hold: assert property (p_hold)
		else $error("pulse while on hold");
	property p_prise;
		$rose(pulse_out) |-> pg_running;
	endproperty
	a_prise: assert property (p_prise)
		else $error("pulse rose while idle");
endmodule

bind trigger_and_pulse_generator trig_asserts chk (.clk, .arst_n, .addr,
	.wdata, .wr_stb, .rd_stb, .rdata, .exposure_active, .pulse_out,
	.pg_running);

// [trig_defs.svh]
// Constants for the trigger front end and internal pulse generator
//
// Overview of operation
// [RULE1] Trigger taken from one of six sources
// [RULE2] Enable lets trigger events start capture
// [RULE3] Internal source uses pulse generator output
// [RULE4] Software trigger: one event, software source only
// [RULE5] Polarity selects rising or falling active edge
// [RULE6] Eight de-bounce choices, off to 10 ms
// [RULE7] De-bounce defaults to 100 us
// [RULE8] Ringing on one pulse yields one trigger
// [RULE9] Programmable delay 0..1000000 us before exposure
// [RULE10] Generator granularity 1x, 10x, 100x or 1000x
// [RULE11] Generator repeats at programmable period
// [RULE12] Pulse high time equals programmable width
// [RULE13] Start command begins, stop command ends pulses
// [RULE14] Status shows generator on hold or running
// [RULE15] Continuous mode runs until stop
// [RULE16] Counted mode emits 1..65500 pulses
// [RULE17] Counted mode returns to idle after last
// [RULE18] Stop aborts counted train immediately
// [RULE19] Pulse-width exposure follows trigger level when enabled
// [RULE20] Period and width scaled by granularity factor
// [RULE21] Accept level after full stable interval; off passes
`ifndef TRIG_DEFS_SVH
`define TRIG_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define US_NS         1000
`define US_CYCLES     ((`US_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DB_T1_US      10
`define DB_T2_US      50
`define DB_T3_US      100
`define DB_T4_US      500
`define DB_T5_US      1000
`define DB_T6_US      5000
`define DB_T7_US      10000
`define DELAY_MAX_US  1000000
`define PULSES_MIN    1
`define PULSES_MAX    65500

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define A_CTRL    8'h00
`define A_DELAY   8'h04
`define A_SWTRIG  8'h08
`define A_PG_CFG  8'h0C
`define A_PERIOD  8'h10
`define A_WIDTH   8'h14
`define A_PULSES  8'h18
`define A_PG_CMD  8'h1C
`define A_STATUS  8'h20

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTRL_EN      0
`define CTRL_SRC_LO  1
`define CTRL_SRC_HI  3
`define CTRL_EDGE    4
`define CTRL_DB_LO   5
`define CTRL_DB_HI   7
`define CTRL_EXP_LO  8
`define CTRL_EXP_HI  9
`define CFG_GRAN_LO  0
`define CFG_GRAN_HI  1
`define CFG_COUNTED  2
`define CMD_START    0
`define CMD_STOP     1
`define SRC_LAST     3'h5
`define EXP_LAST     2'h2
`define DB_RESET     3'h3
`define PERIOD_RESET 20'h00001
`define WIDTH_RESET  20'h00001
`define PULSES_RESET 16'h0001

`endif

// [trig_pkg.sv]
// Types shared by the trigger front end
package trig_pkg;

	// Trigger source select, in register encoding order
	typedef enum logic [2:0] {
		SRC_IN_A,
		SRC_IN_B,
		SRC_CC1,
		SRC_CC2,
		SRC_INTERNAL,
		SRC_SOFT
	} source_e;

	// Exposure control mode
	typedef enum logic [1:0] {
		EXPO_OFF,
		EXPO_PULSE_WIDTH,
		EXPO_INTERNAL
	} expo_e;

	// Exposure delay sequencer
	typedef enum logic {
		DLY_IDLE,
		DLY_WAIT
	} dly_e;

	// Pulse generator process
	typedef enum logic {
		PG_HOLD,
		PG_RUN
	} pg_e;

	// Whole state of the block
	typedef struct packed {
		logic [3:0]  sync1;
		logic [3:0]  sync2;
		logic [15:0] us_cnt;
		logic        trig_en;
		source_e     src;
		logic        falling;
		logic [2:0]  db_sel;
		expo_e       expo;
		logic [19:0] delay_us;
		logic [1:0]  gran;
		logic        counted;
		logic [19:0] period;
		logic [19:0] width;
		logic [15:0] pulses;
		logic        filt;
		logic        filt_prev;
		logic [13:0] db_cnt;
		dly_e        dly;
		logic [19:0] dly_cnt;
		pg_e         pg;
		logic [9:0]  g_cnt;
		logic [19:0] phase;
		logic [15:0] left;
		logic        start_pulse;
		logic        expo_act;
		logic        pulse_lvl;
		logic [31:0] rdata;
	} state_s;

endpackage

// [trig_source_model.sv]
// Far-side model: external pins and cable lines, with optional ringing
`timescale 1ns/10ps

module trig_source_model
(
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [1:0] line,
	input  wire logic       lvl,
	input  wire logic       ring,
	output logic            external_input_a,
	output logic            external_input_b,
	output logic            cable_ctrl_1,
	output logic            cable_ctrl_2
);
	logic [3:0] lv = 4'h0;
	logic [3:0] bounce = 4'h0;
	logic [1:0] sel = 2'h0;
	logic [3:0] mask;

	// Settle level per line; ringing flips the moved line in 2-cycle bursts
	always @(posedge clk)
	begin
		if (go)
		begin
			lv[line] <= lvl;
			sel <= line;
			bounce <= ring ? 4'hF : 4'h0;
		end
		else if (bounce != 4'h0)
			bounce <= bounce - 4'h1;
	end

	// Bursts stay shorter than the shortest filter interval on purpose
	assign mask = (bounce != 4'h0 && bounce[1]) ? (4'h1 << sel) : 4'h0;
	assign {cable_ctrl_2, cable_ctrl_1, external_input_b,
		external_input_a} = lv ^ mask;
endmodule

// [trigger_and_pulse_generator.sv]
// Trigger selection, de-bounce, exposure delay and pulse generator
`timescale 1ns/10ps
`include "trig_defs.svh"

module trigger_and_pulse_generator
	import trig_pkg::*;
#(
	parameter logic [15:0] US_CYCLES = 16'(`US_CYCLES)
)
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [31:0] rdata,
	input  wire logic        external_input_a,
	input  wire logic        external_input_b,
	input  wire logic        cable_ctrl_1,
	input  wire logic        cable_ctrl_2,
	output logic             exposure_start,
	output logic             exposure_active,
	output logic             pulse_out,
	output logic             pg_running
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// De-bounce interval in microseconds for each choice
	function automatic logic [13:0] db_interval(input logic [2:0] sel);
		logic [13:0] v;
		v = 14'h0000;
		case (sel)
			3'h1: v = 14'(`DB_T1_US); // RULE6
			3'h2: v = 14'(`DB_T2_US);
			3'h3: v = 14'(`DB_T3_US);
			3'h4: v = 14'(`DB_T4_US);
			3'h5: v = 14'(`DB_T5_US);
			3'h6: v = 14'(`DB_T6_US);
			3'h7: v = 14'(`DB_T7_US);
			default: v = 14'h0000;
		endcase
		return v;
	endfunction

	// Granularity factor, less one, in microsecond ticks
	function automatic logic [9:0] gran_last(input logic [1:0] g);
		logic [9:0] v;
		v = 10'h000;
		case (g)
			2'h0: v = 10'h000; // RULE10
			2'h1: v = 10'h009;
			2'h2: v = 10'h063;
			default: v = 10'h3E7;
		endcase
		return v;
	endfunction

	// Clamp a written value into an inclusive range
	function automatic logic [31:0] clamp(input logic [31:0] v,
		input logic [31:0] lo, input logic [31:0] hi);
		logic [31:0] r;
		r = v;
		if (v < lo)
		begin
			r = lo;
		end
		else if (v > hi)
		begin
			r = hi;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// State and combinational helpers
	// ----------------------------------------------------------------
	state_s      r_reg;
	state_s      r_next;
	logic        us_tick;
	logic        g_tick;
	logic        raw;
	logic        sw_evt;
	logic        edge_hit;
	logic        evt;
	logic        active_lvl;
	logic [13:0] db_lim;
	logic [19:0] per_last;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------

	// All behaviour is worked out here from the registered state
	always_comb
	begin
		r_next = r_reg;
		r_next.start_pulse = 1'b0;
		r_next.rdata = 32'h0000_0000;

		// Pins pass two flops before anything looks at them
		r_next.sync1 = {cable_ctrl_2, cable_ctrl_1,
			external_input_b, external_input_a};
		r_next.sync2 = r_reg.sync1;

		// Microsecond time base shared by every counter
		us_tick = (r_reg.us_cnt == US_CYCLES - 16'h0001);
		r_next.us_cnt = us_tick ? 16'h0000 : r_reg.us_cnt + 16'h0001;

		// Granularity prescaler runs free on every microsecond tick; a start command clears it
		g_tick = us_tick && (r_reg.g_cnt == gran_last(r_reg.gran));
		if (us_tick)
		begin
			r_next.g_cnt = g_tick ? 10'h000 : r_reg.g_cnt + 10'h001;
		end
		per_last = (r_reg.period == 20'h00000) ? 20'h00000 :
			r_reg.period - 20'h00001;

		// ------------------------------------------------------------
		// Register writes
		// ------------------------------------------------------------
		sw_evt = 1'b0;
		if (wr_stb)
		begin
			if (addr == `A_CTRL)
			begin
				r_next.trig_en = wdata[`CTRL_EN];
				// Unused source codes leave the choice unchanged
				if (wdata[`CTRL_SRC_HI:`CTRL_SRC_LO] <= `SRC_LAST)
				begin
					r_next.src = source_e'(wdata[`CTRL_SRC_HI:`CTRL_SRC_LO]); // RULE1
				end
				r_next.falling = wdata[`CTRL_EDGE]; // RULE5
				r_next.db_sel = wdata[`CTRL_DB_HI:`CTRL_DB_LO];
				if (wdata[`CTRL_EXP_HI:`CTRL_EXP_LO] <= `EXP_LAST)
				begin
					r_next.expo = expo_e'(wdata[`CTRL_EXP_HI:`CTRL_EXP_LO]);
				end
			end
			else if (addr == `A_DELAY)
			begin
				r_next.delay_us = 20'(clamp(wdata, 32'h0,
					32'(`DELAY_MAX_US))); // RULE9
			end
			else if (addr == `A_SWTRIG)
			begin
				// Ignored unless software is the selected source
				sw_evt = wdata[0] && (r_reg.src == SRC_SOFT); // RULE4
			end
			else if (addr == `A_PG_CFG)
			begin
				r_next.gran = wdata[`CFG_GRAN_HI:`CFG_GRAN_LO];
				r_next.counted = wdata[`CFG_COUNTED];
			end
			else if (addr == `A_PERIOD)
			begin
				r_next.period = wdata[19:0];
			end
			else if (addr == `A_WIDTH)
			begin
				r_next.width = wdata[19:0];
			end
			else if (addr == `A_PULSES)
			begin
				r_next.pulses = 16'(clamp(wdata, 32'(`PULSES_MIN),
					32'(`PULSES_MAX))); // RULE16
			end
		end

		// ------------------------------------------------------------
		// Source select and de-bounce
		// ------------------------------------------------------------
		case (r_reg.src)
			SRC_IN_A:     raw = r_reg.sync2[0];
			SRC_IN_B:     raw = r_reg.sync2[1];
			SRC_CC1:      raw = r_reg.sync2[2];
			SRC_CC2:      raw = r_reg.sync2[3];
			SRC_INTERNAL: raw = r_reg.pulse_lvl; // RULE3
			default:      raw = 1'b0;
		endcase

		// A change must hold for the whole interval to be taken
		db_lim = db_interval(r_reg.db_sel);
		if (db_lim == 14'h0000 || r_reg.src == SRC_INTERNAL)
		begin
			r_next.filt = raw; // RULE21
			r_next.db_cnt = 14'h0000;
		end
		else if (raw == r_reg.filt)
		begin
			// Any bounce back restarts the wait
			r_next.db_cnt = 14'h0000; // RULE8
		end
		else if (us_tick)
		begin
			if (r_reg.db_cnt >= db_lim - 14'h0001)
			begin
				r_next.filt = raw; // RULE21
				r_next.db_cnt = 14'h0000;
			end
			else
			begin
				r_next.db_cnt = r_reg.db_cnt + 14'h0001;
			end
		end
		r_next.filt_prev = r_reg.filt;

		// ------------------------------------------------------------
		// Edge detect and enable
		// ------------------------------------------------------------
		edge_hit = r_reg.falling ?
			(r_reg.filt_prev && !r_reg.filt) :
			(!r_reg.filt_prev && r_reg.filt); // RULE5
		if (r_reg.src == SRC_SOFT)
		begin
			evt = sw_evt && r_reg.trig_en; // RULE4
		end
		else
		begin
			evt = edge_hit && r_reg.trig_en; // RULE2
		end

		// Exposure follows the trigger level in pulse-width mode
		active_lvl = r_reg.falling ? !r_reg.filt : r_reg.filt;
		r_next.expo_act = (r_reg.expo == EXPO_PULSE_WIDTH) &&
			r_reg.trig_en && (r_reg.src != SRC_SOFT) &&
			active_lvl; // RULE19

		// ------------------------------------------------------------
		// Exposure delay; triggers during a wait are dropped
		// ------------------------------------------------------------
		case (r_reg.dly)
			DLY_IDLE:
			begin
				if (evt)
				begin
					if (r_reg.delay_us == 20'h00000)
					begin
						r_next.start_pulse = 1'b1; // RULE9
					end
					else
					begin
						r_next.dly_cnt = r_reg.delay_us;
						r_next.dly = DLY_WAIT;
					end
				end
			end
			DLY_WAIT:
			begin
				if (us_tick)
				begin
					r_next.dly_cnt = r_reg.dly_cnt - 20'h00001;
					if (r_reg.dly_cnt == 20'h00001)
					begin
						r_next.start_pulse = 1'b1; // RULE9
						r_next.dly = DLY_IDLE;
					end
				end
			end
			default:
			begin
				r_next.dly = DLY_IDLE;
			end
		endcase

		// ------------------------------------------------------------
		// Pulse generator
		// ------------------------------------------------------------
		case (r_reg.pg)
			PG_HOLD:
			begin
				if (wr_stb && addr == `A_PG_CMD &&
					wdata[`CMD_START] && !wdata[`CMD_STOP])
				begin
					r_next.pg = PG_RUN; // RULE13
					r_next.phase = 20'h00000;
					r_next.g_cnt = 10'h000;
					r_next.left = r_reg.pulses;
				end
			end
			PG_RUN:
			begin
				if (wr_stb && addr == `A_PG_CMD && wdata[`CMD_STOP])
				begin
					// Stop wins at once, also mid counted train
					r_next.pg = PG_HOLD; // RULE18
				end
				else if (g_tick)
				begin
					// One step per granularity tick
					if (r_reg.phase >= per_last)
					begin
						r_next.phase = 20'h00000; // RULE11
						if (r_reg.counted)
						begin
							r_next.left = r_reg.left - 16'h0001;
							if (r_reg.left <= 16'h0001)
							begin
								r_next.pg = PG_HOLD; // RULE17
							end
						end
						// Continuous mode keeps going // RULE15
					end
					else
					begin
						r_next.phase = r_reg.phase + 20'h00001; // RULE20
					end
				end
			end
			default:
			begin
				r_next.pg = PG_HOLD;
			end
		endcase
		r_next.pulse_lvl = (r_next.pg == PG_RUN) &&
			(r_next.phase < r_reg.width); // RULE12

		// ------------------------------------------------------------
		// Register reads, data valid the cycle after the strobe
		// ------------------------------------------------------------
		if (rd_stb)
		begin
			if (addr == `A_CTRL)
			begin
				r_next.rdata = {22'h0, r_reg.expo, r_reg.db_sel,
					r_reg.falling, r_reg.src, r_reg.trig_en};
			end
			else if (addr == `A_DELAY)
			begin
				r_next.rdata = {12'h000, r_reg.delay_us};
			end
			else if (addr == `A_PG_CFG)
			begin
				r_next.rdata = {29'h0, r_reg.counted, r_reg.gran};
			end
			else if (addr == `A_PERIOD)
			begin
				r_next.rdata = {12'h000, r_reg.period};
			end
			else if (addr == `A_WIDTH)
			begin
				r_next.rdata = {12'h000, r_reg.width};
			end
			else if (addr == `A_PULSES)
			begin
				r_next.rdata = {16'h0000, r_reg.pulses};
			end
			else if (addr == `A_STATUS)
			begin
				r_next.rdata = {28'h0, r_reg.filt,
					(r_reg.dly == DLY_WAIT), r_reg.expo_act,
					(r_reg.pg == PG_RUN)}; // RULE14
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Reset leaves the trigger disabled and the generator on hold
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			r_reg <= '0;
			r_reg.src <= SRC_IN_A;
			r_reg.expo <= EXPO_OFF;
			r_reg.db_sel <= `DB_RESET; // RULE7
			r_reg.dly <= DLY_IDLE;
			r_reg.pg <= PG_HOLD;
			r_reg.period <= `PERIOD_RESET;
			r_reg.width <= `WIDTH_RESET;
			r_reg.pulses <= `PULSES_RESET;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign rdata = r_reg.rdata;
	assign exposure_start = r_reg.start_pulse;
	assign exposure_active = r_reg.expo_act;
	assign pulse_out = r_reg.pulse_lvl;
	assign pg_running = (r_reg.pg == PG_RUN);

endmodule
